// >>> rtl/csp_current_sense.sv
// Digital timing core of a floating phase current sensor with APB access.
// Assumes sync, sense level and fault comparator are synchronous to clock.
//
// Function
// [RULE_01] The sync input is the only timing reference and the controller keeps it locked to its PWM carrier.
// [RULE_02] Sync high half-periods form channel one and low half-periods channel two, one result each.
// [RULE_03] Each channel keeps its own period and result so sync duty deviations cancel out.
// [RULE_04] The controller compensates offset separately for each channel.
// [RULE_05] The pulse output is active low open drain, only ever pulled low.
// [RULE_06] Duty n is the low time in half-period n+1 over the length of half-period n.
// [RULE_07] The duty is clamped between 10 and 30 percent.
// [RULE_08] Zero sense voltage gives 20 percent duty.
// [RULE_09] The fault flag goes low only after the over-current condition held for the debounce time.
// [RULE_10] The fault stays latched until the pulse pin is held low externally for the clear time.
// [RULE_11] While the fault is latched the pulse output is released.
// [RULE_12] A fault cleared while over-current persists is reasserted at the next sync edge.
// [RULE_13] Tying the fault pin to the pulse pin gives automatic clearing.
// [RULE_14] The pulse rising edge comes within 30 percent of the half-period after the sync edge.
// [RULE_15] The duty falls linearly from 20 percent by 40 percent per volt of sense input.
// [RULE_16] The integrator range straps are set by the board according to PWM frequency.
// [RULE_17] After reset the fault latch and pulse output are released until a sync edge starts timing; the code can latch a fault before any sync edge.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module csp_current_sense
  import csp_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire csp_pkg::csp_apb_req_t apb_req,
  output      csp_pkg::csp_apb_rsp_t apb_rsp,
  input  wire logic                sync,
  input  wire logic signed [15:0]  sense_mv,
  input  wire logic                fault_threshold,
  input  wire logic                integrator_range_low,
  input  wire logic                integrator_range_high,
  input  wire logic                pulse_width_output_in,
  output      csp_pkg::csp_od_t    pulse_width_output,
  input  wire logic                overcurrent_flag_in,
  output      csp_pkg::csp_od_t    overcurrent_flag,
  output      logic                irq
);
  import csp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Per-mille duty from sense voltage, clamped
  function automatic logic [DUTY_W-1:0] duty_of(input logic signed [15:0] mv);
    int d;
    d = DUTY_ZERO_PM - (int'(mv) * DUTY_SLOPE_PM) / PM_SCALE; // RULE_15 RULE_08
    if (d < DUTY_MIN_PM) begin
      d = DUTY_MIN_PM; // RULE_07
    end
    if (d > DUTY_MAX_PM) begin
      d = DUTY_MAX_PM; // RULE_07
    end
    return DUTY_W'(d);
  endfunction

  // Low time in cycles for a given period and duty
  function automatic logic [PER_W-1:0] off_of(input logic [PER_W-1:0]  per,
                                               input logic [DUTY_W-1:0] duty);
    logic [PER_W+DUTY_W-1:0] prod;
    prod = per * duty;
    return PER_W'(prod / (PER_W+DUTY_W)'(PM_SCALE));
  endfunction

  // Register select on one aligned word offset
  function automatic logic reg_sel(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // Offsets that hold a register
  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    logic known;
    unique case (addr)
      CTRL_OFS, STATUS_OFS, CH1_OFS, CH2_OFS,
      IRQ_STS_OFS, IRQ_MSK_OFS: known = 1'b1;
      default:                  known = 1'b0;
    endcase
    return known;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                 sync_q_ff;
  logic                 sync_edge;
  logic                 started_ff;
  logic                 valid_ff;
  logic [PER_W-1:0]     per_cnt_ff;
  logic [PER_W-1:0]     low_cnt_ff;
  logic                 drive_low_ff;
  csp_result_t          result_ff [2];
  logic                 ch_done;
  logic                 ch_end;
  csp_result_t          nxt_result;

  csp_oc_state_t        oc_state_ff;
  logic [CNT_W-1:0]     deb_cnt_ff;
  logic [CNT_W-1:0]     clr_cnt_ff;
  logic                 oc_set;
  logic                 oc_clr;
  logic                 oc_latched;

  logic                 enable_ff;
  logic [IRQ_W-1:0]     irq_sts_ff;
  logic [IRQ_W-1:0]     irq_msk_ff;
  logic [IRQ_W-1:0]     irq_evt;
  logic [DATA_W-1:0]    rdata_ff;
  logic                 slverr_ff;
  logic                 setup;
  logic                 access;
  logic                 wr_en;
  logic                 mapped;
  logic                 wr_ctrl;
  logic                 wr_irq_sts;
  logic                 wr_irq_msk;
  logic [DATA_W-1:0]    nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Sync edge detection and start-up

  assign sync_edge = started_ff ? (sync != sync_q_ff) : 1'b0; // RULE_01
  assign ch_end    = sync_q_ff;  // 1: channel one half-period just ended

  always_ff @(posedge clock) begin
    if (reset) begin
      sync_q_ff  <= 1'b0;
      started_ff <= 1'b0;
    end else begin
      sync_q_ff  <= sync;
      started_ff <= 1'b1;
    end
  end

  // First edge only starts period timing; output waits for a measured period
  always_ff @(posedge clock) begin
    if (reset) begin
      valid_ff <= 1'b0; // RULE_17
    end else if (sync_edge) begin
      valid_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Half-period measurement per channel

  always_ff @(posedge clock) begin
    if (reset) begin
      per_cnt_ff <= '0;
    end else if (sync_edge) begin
      per_cnt_ff <= PER_W'(1);
    end else if (per_cnt_ff != '1) begin
      per_cnt_ff <= per_cnt_ff + PER_W'(1);
    end
  end

  always_comb begin
    nxt_result.period  = per_cnt_ff;
    nxt_result.duty    = duty_of(sense_mv);
    nxt_result.off_cnt = off_of(per_cnt_ff, duty_of(sense_mv)); // RULE_06
  end

  assign ch_done = sync_edge && valid_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      result_ff[0] <= '0;
      result_ff[1] <= '0;
    end else if (ch_done) begin
      if (ch_end) begin
        result_ff[0] <= nxt_result; // RULE_02 RULE_03
      end else begin
        result_ff[1] <= nxt_result; // RULE_02 RULE_03
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse output: low phase at the start of each half-period

  always_ff @(posedge clock) begin
    if (reset) begin
      low_cnt_ff   <= '0;
      drive_low_ff <= 1'b0; // RULE_17
    end else if (oc_latched || !enable_ff) begin
      low_cnt_ff   <= '0;
      drive_low_ff <= 1'b0; // RULE_11
    end else if (ch_done && enable_ff && nxt_result.off_cnt != '0) begin
      low_cnt_ff   <= nxt_result.off_cnt - PER_W'(1); // RULE_14
      drive_low_ff <= 1'b1; // RULE_06
    end else if (ch_done || low_cnt_ff == '0) begin
      low_cnt_ff   <= '0;
      drive_low_ff <= 1'b0; // RULE_14
    end else begin
      low_cnt_ff   <= low_cnt_ff - PER_W'(1);
    end
  end

  // Open drain: only pulls low, released during a fault
  assign pulse_width_output.out  = 1'b0; // RULE_05
  assign pulse_width_output.oe_n = ~(drive_low_ff && !oc_latched); // RULE_11 RULE_05

  ////////////////////////////////////////////////////////////////////////////////
  // Over-current debounce, latch and clear

  assign oc_latched = (oc_state_ff == OC_LATCHED);
  assign oc_set     = (oc_state_ff == OC_IDLE && fault_threshold
                       && deb_cnt_ff == CNT_W'(DEBOUNCE_CYCLES - 1))
                      || (oc_state_ff == OC_REARM && fault_threshold && sync_edge);
  assign oc_clr     = oc_latched && !pulse_width_output_in
                      && clr_cnt_ff == CNT_W'(CLEAR_CYCLES - 1);

  always_ff @(posedge clock) begin
    if (reset) begin
      deb_cnt_ff <= '0;
    end else if (!fault_threshold || oc_state_ff != OC_IDLE) begin
      deb_cnt_ff <= '0; // RULE_09
    end else if (deb_cnt_ff != CNT_W'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_ff <= deb_cnt_ff + CNT_W'(1); // RULE_09
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      clr_cnt_ff <= '0;
    end else if (!oc_latched || pulse_width_output_in) begin
      clr_cnt_ff <= '0; // RULE_10
    end else if (clr_cnt_ff != CNT_W'(CLEAR_CYCLES - 1)) begin
      clr_cnt_ff <= clr_cnt_ff + CNT_W'(1); // RULE_10 RULE_13
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      oc_state_ff <= OC_IDLE; // RULE_17
    end else begin
      unique case (oc_state_ff)
        OC_IDLE: begin
          if (oc_set) begin
            oc_state_ff <= OC_LATCHED; // RULE_09
          end
        end
        OC_LATCHED: begin
          if (oc_clr) begin
            oc_state_ff <= fault_threshold ? OC_REARM : OC_IDLE; // RULE_10
          end
        end
        OC_REARM: begin
          if (oc_set) begin
            oc_state_ff <= OC_LATCHED; // RULE_12
          end else if (!fault_threshold) begin
            oc_state_ff <= OC_IDLE;
          end
        end
      endcase
    end
  end

  assign overcurrent_flag.out  = 1'b0;
  assign overcurrent_flag.oe_n = ~oc_latched; // RULE_09 RULE_10

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  always_comb begin
    irq_evt               = '0;
    irq_evt[IRQ_CH1_DONE] = ch_done && ch_end;
    irq_evt[IRQ_CH2_DONE] = ch_done && !ch_end;
    irq_evt[IRQ_OC_SET]   = oc_set;
    irq_evt[IRQ_OC_CLR]   = oc_clr;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_sts_ff <= '0;
    end else if (wr_irq_sts) begin
      irq_sts_ff <= (irq_sts_ff & ~apb_req.pwdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_sts_ff <= irq_sts_ff | irq_evt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_msk_ff <= IRQ_MSK_RST;
    end else if (wr_irq_msk) begin
      irq_msk_ff <= apb_req.pwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_sts_ff & irq_msk_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  assign setup  = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr_en  = access && apb_req.pwrite && mapped;
  assign mapped     = reg_known(apb_req.paddr);
  assign wr_ctrl    = wr_en && reg_sel(apb_req.paddr, CTRL_OFS);
  assign wr_irq_sts = wr_en && reg_sel(apb_req.paddr, IRQ_STS_OFS);
  assign wr_irq_msk = wr_en && reg_sel(apb_req.paddr, IRQ_MSK_OFS);

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_ff <= CTRL_ENABLE_RST;
    end else if (wr_ctrl) begin
      enable_ff <= apb_req.pwdata[0];
    end
  end

  always_comb begin
    nxt_rdata = '0;
    unique case (apb_req.paddr)
      CTRL_OFS:    nxt_rdata[0] = enable_ff;
      STATUS_OFS:  nxt_rdata[5:0] = {integrator_range_high, integrator_range_low,
                                     overcurrent_flag_in, sync_q_ff, valid_ff, oc_latched};
      CH1_OFS:     nxt_rdata = {result_ff[0].period, result_ff[0].off_cnt};
      CH2_OFS:     nxt_rdata = {result_ff[1].period, result_ff[1].off_cnt};
      IRQ_STS_OFS: nxt_rdata[IRQ_W-1:0] = irq_sts_ff;
      IRQ_MSK_OFS: nxt_rdata[IRQ_W-1:0] = irq_msk_ff;
      default:     nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_ff  <= '0;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      rdata_ff  <= apb_req.pwrite ? '0 : nxt_rdata;
      slverr_ff <= !mapped;
    end
  end

  assign apb_rsp.prdata  = rdata_ff;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = access && slverr_ff;

endmodule

// >>> rtl/csp_pkg.sv
// Constants, register map and carrier types for the current sense timing block.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
package csp_pkg;

  // Clock rate
  localparam int unsigned CLK_FREQ_MHZ = 10;

  // Debounce and clear times in nanoseconds
  localparam int unsigned FAULT_DEBOUNCE_TIME_NS   = 3500;
  localparam int unsigned FAULT_CLEAR_PULSE_TIME_NS = 500;

  // Cycle counts: debounce at its typical figure, clear rounded down
  localparam int unsigned DEBOUNCE_CYCLES = (FAULT_DEBOUNCE_TIME_NS * CLK_FREQ_MHZ) / 1000;
  localparam int unsigned CLEAR_CYCLES    = (FAULT_CLEAR_PULSE_TIME_NS * CLK_FREQ_MHZ) / 1000;

  // Duty cycle transfer in per-mille and per-mille per volt
  localparam int DUTY_ZERO_PM  = 200;
  localparam int DUTY_MIN_PM   = 100;
  localparam int DUTY_MAX_PM   = 300;
  localparam int DUTY_SLOPE_PM = 400;
  localparam int PM_SCALE      = 1000;

  // Widths
  localparam int unsigned PER_W  = 16;
  localparam int unsigned DUTY_W = 9;
  localparam int unsigned CNT_W  = 6;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IRQ_W  = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] CH1_OFS     = 8'h08;
  localparam logic [ADDR_W-1:0] CH2_OFS     = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_MSK_OFS = 8'h14;

  // Reset values
  localparam logic             CTRL_ENABLE_RST = 1'h1;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST     = 4'h0;

  // Interrupt bit positions
  localparam int unsigned IRQ_CH1_DONE = 0;
  localparam int unsigned IRQ_CH2_DONE = 1;
  localparam int unsigned IRQ_OC_SET   = 2;
  localparam int unsigned IRQ_OC_CLR   = 3;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } csp_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } csp_apb_rsp_t;

  // Open-drain pin: output level and active-low enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } csp_od_t;

  // Latched result of one channel
  typedef struct packed {
    logic [PER_W-1:0]  period;
    logic [DUTY_W-1:0] duty;
    logic [PER_W-1:0]  off_cnt;
  } csp_result_t;

  typedef enum logic [1:0] {
    OC_IDLE,
    OC_LATCHED,
    OC_REARM
  } csp_oc_state_t;

endpackage

// >>> verification/csp_chk.sv
// Port checker for the current sense timing block.
// Assumes it is bound into csp_current_sense and sees only its ports.
`timescale 1ns/1ps
module csp_chk
  import csp_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              sync,
  input wire logic              fault_threshold,
  input wire logic              pulse_width_output_in,
  input wire csp_pkg::csp_od_t  pulse_width_output,
  input wire csp_pkg::csp_od_t  overcurrent_flag
);
  logic        sync_ff;
  logic [1:0]  se_ff;
  logic [15:0] hp_ff;
  logic [15:0] lp_ff;
  logic [15:0] lc_ff;
  logic [15:0] th_ff;
  wire         tog = (sync != sync_ff);
  ////////////////////////////////////////////////////////////////////////////
  // Half-period, low phase and threshold run lengths
  always_ff @(posedge clock) begin
    sync_ff <= sync;
    hp_ff   <= (reset || tog) ? 16'h0000 : hp_ff + 16'h0001;
    lp_ff   <= reset ? 16'h0000 : (tog ? hp_ff + 16'h0001 : lp_ff);
    se_ff   <= reset ? 2'h0 : ((tog && se_ff != 2'h2) ? se_ff + 2'h1 : se_ff);
    lc_ff   <= pulse_width_output.oe_n ? 16'h0000 : lc_ff + 16'h0001;
    th_ff   <= (reset || !fault_threshold) ? 16'h0000 : th_ff + 16'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  od_low_only_a: assert property (
    !pulse_width_output.out && !overcurrent_flag.out) else $error("pin driven high");
  debounce_span_a: assert property (
    $fell(overcurrent_flag.oe_n) |-> th_ff >= 16'h0023) else $error("fault too early");
  debounce_early_a: assert property (
    $rose(fault_threshold) && overcurrent_flag.oe_n |=> overcurrent_flag.oe_n [*7])
    else $error("fault not debounced");
  fault_hold_a: assert property (
    $rose(overcurrent_flag.oe_n) |-> !$past(pulse_width_output_in)) else $error("fault dropped");
  fault_clear_a: assert property (
    (!overcurrent_flag.oe_n && !pulse_width_output_in) ##1 (!pulse_width_output_in) [*5]
    |-> overcurrent_flag.oe_n) else $error("fault not cleared");
  fault_mute_a: assert property (
    !overcurrent_flag.oe_n [*2] |-> pulse_width_output.oe_n) else $error("pulse during fault");
  duty_max_a: assert property (
    !pulse_width_output.oe_n |-> lc_ff * 10 < lp_ff * 3) else $error("low phase too long");
  low_start_a: assert property (
    $fell(pulse_width_output.oe_n) |-> hp_ff <= 16'h0002) else $error("late low phase");
  start_quiet_a: assert property (
    se_ff != 2'h2 |-> pulse_width_output.oe_n) else $error("pulse before timing");
endmodule
bind csp_current_sense csp_chk u_chk (.clock(clock), .reset(reset), .sync(sync),
  .fault_threshold(fault_threshold), .pulse_width_output_in(pulse_width_output_in),
  .pulse_width_output(pulse_width_output), .overcurrent_flag(overcurrent_flag));

// >>> verification/csp_ctrl_model.sv
// Controller model: makes the sync carrier and pulls the pulse pin low to clear.
// Assumes the bench folds its pull output into the pulse pin wire.
`timescale 1ns/1ps
module csp_ctrl_model #(
  parameter int HI  = 90,
  parameter int LO  = 110,
  parameter int CLR = 6
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic run,
  input  wire logic clr_go,
  output      logic sync,
  output      logic pull
);
  int cnt;
  int pc;
  assign pull = (pc != 0);
  always_ff @(posedge clock) begin
    if (reset) begin
      sync <= 1'b0;
      cnt  <= 0;
    end else if (run && cnt >= (sync ? HI : LO) - 1) begin
      sync <= !sync;
      cnt  <= 0;
    end else if (run) begin
      cnt <= cnt + 1;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) pc <= 0;
    else if (clr_go && pc == 0) pc <= CLR;
    else if (pc != 0) pc <= pc - 1;
  end
endmodule

// >>> verification/csp_current_sense_tb_top.sv
// Testbench for the current sense timing block.
// Assumes the controller model and the checker are compiled before it.
`timescale 1ns/1ps
module current_sense_pwm_overcurrent_latch_tb_top;
  import csp_pkg::*;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               run = 1'b0;
  logic               clr_go = 1'b0;
  logic               tie = 1'b0;
  logic               thr = 1'b0;
  logic signed [15:0] sense_mv = 16'sh0000;
  csp_apb_req_t       apb_req = '0;
  csp_apb_rsp_t       apb_rsp;
  csp_od_t            pwo;
  csp_od_t            ocf;
  logic               sync, pull, pw_pin, irq, slverr;
  logic               sync_q = 1'b0;
  logic [3:0]         obs;
  logic [15:0]        lowcnt = 16'h0000;
  logic [15:0]        lowq [2];
  logic [31:0]        q;
  int                 mismatches = 0;
  int                 tests_run = 0;
  always #50 clock = ~clock;
  assign pw_pin = pwo.oe_n && !pull && !(tie && !ocf.oe_n);
  csp_current_sense dut (.clock(clock), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sync(sync), .sense_mv(sense_mv), .fault_threshold(thr), .integrator_range_low(1'b1),
    .integrator_range_high(1'b0), .pulse_width_output_in(pw_pin), .pulse_width_output(pwo),
    .overcurrent_flag_in(tie ? pw_pin : ocf.oe_n), .overcurrent_flag(ocf), .irq(irq));
  csp_ctrl_model ctl (.clock(clock), .reset(reset), .run(run), .clr_go(clr_go), .sync(sync),
    .pull(pull));
  ////////////////////////////////////////////////////////////////////////////
  // Settled outputs and low cycles per sync half
  always @(negedge clock) begin
    obs    <= {irq, ocf.oe_n, pwo.oe_n, pw_pin};
    sync_q <= sync;
    if (sync != sync_q) begin
      lowq[sync_q] <= lowcnt;
      lowcnt <= 16'(!pw_pin);
    end else lowcnt <= lowcnt + 16'(!pw_pin);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apb_rsp.pready !== 1'b1);
    q      = apb_rsp.prdata;
    slverr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  function automatic logic [15:0] ex(input int p, input int mv);
    int d;
    d = 200 - mv * 400 / 1000;
    d = d < 100 ? 100 : (d > 300 ? 300 : d);
    return 16'(p * d / 1000);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cyc(200);
    chk(obs, 32'h7);
    apb(0, CTRL_OFS, 0);
    chk(q, 32'h1);
    apb(0, IRQ_MSK_OFS, 0);
    chk(q, 32'h0);
    apb(0, STATUS_OFS, 0);
    chk(q & 32'h38, 32'h18);
    apb(0, 8'h40, 0);
    chk({q[30:0], slverr}, 32'h1);
  endtask
  task automatic t_duty;
    int mv [5] = '{0, 100, -100, 250, -300};
    foreach (mv[i]) begin
      sense_mv <= 16'(mv[i]);
      cyc(500);
      chk({16'h0000, lowq[0]}, {16'h0000, ex(90, mv[i])});
      chk({16'h0000, lowq[1]}, {16'h0000, ex(110, mv[i])});
      apb(0, CH1_OFS, 0);
      chk(q, {16'h005A, ex(90, mv[i])});
      apb(0, CH2_OFS, 0);
      chk(q, {16'h006E, ex(110, mv[i])});
    end
  endtask
  task automatic t_fault;
    int n;
    thr <= 1'b1;
    cyc(20);
    thr <= 1'b0;
    cyc(2);
    chk(obs[2], 1);
    thr <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (obs[2] && n < 60);
    chk(n, 36);
    n = 0;
    repeat (300) begin @(posedge clock); n += int'(!obs[0]); end
    chk(n, 0);
    clr_go <= 1'b1;
    @(posedge clock);
    clr_go <= 1'b0;
    n = 0;
    do begin @(posedge clock); n++; end while (!obs[2] && n < 20);
    chk(n < 20, 1);
    n = 0;
    do begin @(posedge clock); n++; end while (obs[2] && n < 130);
    chk(n < 130, 1);
    thr <= 1'b0;
    clr_go <= 1'b1;
    @(posedge clock);
    clr_go <= 1'b0;
    cyc(200);
    chk(obs[2], 1);
  endtask
  task automatic t_auto;
    tie <= 1'b1;
    apb(1, IRQ_STS_OFS, 32'hF);
    thr <= 1'b1;
    cyc(40);
    thr <= 1'b0;
    cyc(30);
    chk(obs[2], 1);
    apb(0, IRQ_STS_OFS, 0);
    chk(q & 32'hC, 32'hC);
    tie <= 1'b0;
  endtask
  task automatic t_en;
    apb(1, CTRL_OFS, 32'h0);
    cyc(500);
    chk({lowq[0], lowq[1]}, 32'h0);
    apb(1, CTRL_OFS, 32'h1);
  endtask
  task automatic t_irq;
    run <= 1'b0;
    apb(1, IRQ_MSK_OFS, 32'h3);
    cyc(2);
    chk(obs[3], 1);
    apb(1, IRQ_MSK_OFS, 32'h0);
    cyc(2);
    chk(obs[3], 0);
    apb(1, IRQ_MSK_OFS, 32'h3);
    apb(1, IRQ_STS_OFS, 32'hF);
    cyc(2);
    chk(obs[3], 0);
    apb(0, IRQ_STS_OFS, 0);
    chk(q, 32'h0);
  endtask
  task automatic results;
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(5);
    reset <= 1'b0;
    t_reset();
    run <= 1'b1;
    t_duty();
    t_fault();
    t_auto();
    t_en();
    t_irq();
    results();
  end
  initial begin
    cyc(20000);
    mismatches++;
    results();
  end
endmodule
